/* File: inc/spp_pkg.sv */
// Purpose: shared types and constants for the serial peripheral port
// Assumes: 16-bit data path, byte mode uses the low eight bits
// Notes:   configuration and status travel as packed structs

package spp_pkg;

  // ----------------------------------------------------------------
  // sizes and levels
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] LVL_ENH = 6'h08;
  localparam logic [CNT_W-1:0] LVL_STD = 6'h01;
  localparam logic [3:0] MSB_WORD = 4'hF;
  localparam logic [3:0] MSB_BYTE = 4'h7;
  localparam logic [WORD_W-1:0] MASK_WORD = 16'hFFFF;
  localparam logic [WORD_W-1:0] MASK_BYTE = 16'h00FF;
  localparam logic [5:0] HALF_WORD = 6'h20;
  localparam logic [5:0] HALF_BYTE = 6'h10;
  localparam logic [7:0] DIV_RST = 8'h00;

  // ----------------------------------------------------------------
  // master sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPP_IDLE = 2'h0,
    SPP_SHIFT = 2'h1,
    SPP_TAIL = 2'h3
  } spp_state_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic master;
    logic fifo_en;
    logic word_width_select;
    logic cke;
    logic ckp;
    logic input_sample_phase;
    logic slave_select_enable;
    logic dis_sdo;
    logic dis_sck;
    logic frame_en;
    logic frame_pol;
  } spp_cfg_s;

  typedef struct packed {
    logic tx_full;
    logic rx_full;
    logic rx_ovf;
    logic rx_empty;
    logic sr_empty;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W-1:0] rx_cnt;
  } spp_stat_s;

endpackage : spp_pkg

/* File: logic/spp_top.sv */
// Purpose: serial peripheral port, master or slave, standard or fifo
// Assumes: config changes only while module_enable is low
// Notes:   slave logic runs on the shift clock pin
//
// Function
// - single buffer or eight-entry fifo modes
// - framed protocol, master or slave, four configurations
// - data in, data out, clock, select pins
// - four, three or two pin use
// - master starts on data buffer write
// - master_enable picks master or slave role
// - nothing runs unless module_enable set
// - fifo_buffer_enable selects eight-entry fifo
// - overflow flag set, new data discarded
// - word_width_select picks 16 or 8 bits
// - transmit_full_flag set on write, cleared on move
// - receive_full_flag set on fill, cleared on read

// ------------------------------------------------------------------
// fifo
// ------------------------------------------------------------------
module spp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clr_i,
  // usable level
  input wire logic [$clog2(DEPTH+1)-1:0] limit_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  // level
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_reg < limit_i);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rd_reg];
  assign count_o = cnt_reg;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_ent
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          mem_reg[g] <= '0;
        end else if (push && wr_reg == AW'(g)) begin
          mem_reg[g] <= in_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (clr_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= AW'(wr_reg + 1'b1);
      end
      if (pop) begin
        rd_reg <= AW'(rd_reg + 1'b1);
      end
      cnt_reg <= CW'(cnt_reg + CW'(push) - CW'(pop));
    end
  end
endmodule : spp_fifo

// ------------------------------------------------------------------
// top
// ------------------------------------------------------------------
module spp_top
  import spp_pkg::*;
(
  // system clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // configuration and status
  input wire spp_cfg_s cfg_i,
  input wire logic [7:0] clk_div_i,
  input wire logic ovf_clr_i,
  output spp_stat_s stat_o,
  // data buffer, write side
  input wire logic buf_wr_i,
  input wire logic [WORD_W-1:0] buf_wdata_i,
  output logic buf_wr_ready_o,
  // data buffer, read side
  input wire logic buf_rd_i,
  output logic buf_rvalid_o,
  output logic [WORD_W-1:0] buf_rdata_o,
  // link pins
  input wire logic shift_clock_i,
  output logic shift_clock_o,
  output logic shift_clock_oe_o,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  input wire logic slave_select_n_i,
  output logic slave_select_n_o,
  output logic slave_select_n_oe_o
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  spp_state_e st_reg;
  logic [7:0] div_reg;
  logic [5:0] hcnt_reg;
  logic act_reg;
  logic [WORD_W-1:0] mtx_reg;
  logic [WORD_W-1:0] mrx_reg;
  logic mdone_reg;
  logic sdi1_reg;
  logic sdi2_reg;
  logic ovf_reg;
  logic [WORD_W-1:0] stage_reg;
  logic req_reg;
  logic ak1_reg;
  logic ak2_reg;
  logic rt1_reg;
  logic rt2_reg;
  logic rt3_reg;
  logic [4:0] scnt_reg;
  logic [4:0] ocnt_reg;
  logic [WORD_W-1:0] srx_reg;
  logic [WORD_W-1:0] shold_reg;
  logic stg_reg;
  logic sack_reg;
  logic sreq1_reg;
  logic sreq2_reg;
  logic tick;
  logic ev_lead;
  logic ev_trail;
  logic ev_tail;
  logic ev_shift;
  logic ev_samp;
  logic [5:0] hlast;
  logic [3:0] msb;
  logic [WORD_W-1:0] mask;
  logic m_run;
  logic s_run;
  logic stage_free;
  logic s_pend;
  logic s_new;
  logic fs_act;
  logic sclk;
  logic srst_n;
  logic hrst_n;
  logic s_last;
  logic tx_in_rdy;
  logic [WORD_W-1:0] s_word;
  logic [3:0] oidx;
  logic tx_valid;
  logic tx_ready;
  logic [WORD_W-1:0] tx_data;
  logic rx_push;
  logic rx_ready;
  logic [WORD_W-1:0] rx_data;
  logic [CNT_W-1:0] lvl;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  assign m_run = cfg_i.en & cfg_i.master;
  assign s_run = cfg_i.en & ~cfg_i.master;
  assign lvl = cfg_i.fifo_en ? LVL_ENH : LVL_STD;
  assign msb = cfg_i.word_width_select ? MSB_WORD : MSB_BYTE;
  assign mask = cfg_i.word_width_select ? MASK_WORD : MASK_BYTE;
  assign hlast = cfg_i.word_width_select ? HALF_WORD : HALF_BYTE;

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  spp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clr_i(~cfg_i.en),
    .limit_i(lvl),
    .in_valid_i(buf_wr_i & cfg_i.en),
    .in_ready_o(tx_in_rdy),
    .in_data_i(buf_wdata_i),
    .out_valid_o(tx_valid),
    .out_ready_i(tx_ready),
    .out_data_o(tx_data),
    .count_o(stat_o.tx_cnt)
  );

  spp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clr_i(~cfg_i.en),
    .limit_i(lvl),
    .in_valid_i(rx_push),
    .in_ready_o(rx_ready),
    .in_data_i(rx_data),
    .out_valid_o(buf_rvalid_o),
    .out_ready_i(buf_rd_i),
    .out_data_o(buf_rdata_o),
    .count_o(stat_o.rx_cnt)
  );

  // tx pop moves a word into the shift path
  assign buf_wr_ready_o = tx_in_rdy & cfg_i.en;
  assign stage_free = (req_reg == ak2_reg);
  assign tx_ready = (m_run & st_reg == SPP_IDLE) | (s_run & stage_free);
  assign rx_push = mdone_reg | s_new;
  assign rx_data = (cfg_i.master ? mrx_reg : shold_reg) & mask;

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  assign stat_o.tx_full = ~tx_in_rdy;
  assign stat_o.rx_full = ~rx_ready;
  assign stat_o.rx_ovf = ovf_reg;
  assign stat_o.rx_empty = ~buf_rvalid_o;
  assign stat_o.sr_empty = cfg_i.master ? (st_reg == SPP_IDLE) : stage_free;

  // overflow: a set in the clearing cycle wins
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovf_reg <= 1'b0;
    end else if (rx_push && !rx_ready) begin
      ovf_reg <= 1'b1;
    end else if (ovf_clr_i) begin
      ovf_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // master: clock generation and sequencing
  // ----------------------------------------------------------------
  assign tick = (st_reg != SPP_IDLE) && (div_reg == clk_div_i);
  assign ev_lead = tick & (st_reg == SPP_SHIFT) & ~hcnt_reg[0];
  assign ev_trail = tick & (st_reg == SPP_SHIFT) & hcnt_reg[0];
  assign ev_tail = tick & (st_reg == SPP_TAIL);
  assign ev_shift = cfg_i.cke ? ev_trail : (ev_lead & hcnt_reg != 6'h00);
  assign ev_samp = cfg_i.input_sample_phase ? (ev_shift | (ev_tail & ~cfg_i.cke))
                             : (cfg_i.cke ? ev_lead : ev_trail);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= SPP_IDLE;
      hcnt_reg <= 6'h00;
      act_reg <= 1'b0;
    end else if (!m_run) begin
      st_reg <= SPP_IDLE;
      hcnt_reg <= 6'h00;
      act_reg <= 1'b0;
    end else begin
      case (st_reg)
        SPP_IDLE: begin
          if (tx_valid) begin
            st_reg <= SPP_SHIFT;
            hcnt_reg <= 6'h00;
          end
        end
        SPP_SHIFT: begin
          if (tick) begin
            act_reg <= ~act_reg;
            hcnt_reg <= 6'(hcnt_reg + 1'b1);
            if (hcnt_reg == 6'(hlast - 1'b1)) begin
              st_reg <= SPP_TAIL;
            end
          end
        end
        SPP_TAIL: begin
          if (tick) begin
            st_reg <= SPP_IDLE;
          end
        end
        default: begin
          st_reg <= SPP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg <= DIV_RST;
    end else if (tick || st_reg == SPP_IDLE) begin
      div_reg <= DIV_RST;
    end else begin
      div_reg <= 8'(div_reg + 1'b1);
    end
  end

  // shift data, msb first
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mtx_reg <= '0;
    end else if (m_run && st_reg == SPP_IDLE && tx_valid) begin
      mtx_reg <= tx_data;
    end else if (ev_shift) begin
      mtx_reg <= {mtx_reg[WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sdi1_reg <= 1'b0;
      sdi2_reg <= 1'b0;
      mrx_reg <= '0;
      mdone_reg <= 1'b0;
    end else begin
      sdi1_reg <= serial_data_in_i;
      sdi2_reg <= sdi1_reg;
      mdone_reg <= ev_tail;
      if (ev_samp) begin
        mrx_reg <= {mrx_reg[WORD_W-2:0], sdi2_reg};
      end
    end
  end

  // ----------------------------------------------------------------
  // crossings between system and link domains
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage_reg <= '0;
      req_reg <= 1'b0;
    end else if (!s_run) begin
      req_reg <= 1'b0;
    end else if (stage_free && tx_valid) begin
      stage_reg <= tx_data;
      req_reg <= ~req_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ak1_reg <= 1'b0;
      ak2_reg <= 1'b0;
      rt1_reg <= 1'b0;
      rt2_reg <= 1'b0;
      rt3_reg <= 1'b0;
    end else begin
      ak1_reg <= sack_reg;
      ak2_reg <= ak1_reg;
      rt1_reg <= stg_reg;
      rt2_reg <= rt1_reg;
      rt3_reg <= rt2_reg;
    end
  end

  assign s_new = s_run & (rt2_reg ^ rt3_reg);

  // ----------------------------------------------------------------
  // slave: logic clocked by the shift clock pin
  // ----------------------------------------------------------------
  assign sclk = shift_clock_i ^ cfg_i.ckp ^ cfg_i.cke;
  // toggles and words survive deselection, only the bit count restarts
  assign hrst_n = rstn_i & s_run;
  assign srst_n = hrst_n &
                  ~(cfg_i.slave_select_enable & ~cfg_i.frame_en & slave_select_n_i);
  assign fs_act = cfg_i.frame_en & (slave_select_n_i == cfg_i.frame_pol);
  assign s_word = {srx_reg[WORD_W-2:0], serial_data_in_i};
  assign s_last = ~fs_act & (scnt_reg[3:0] == msb);

  always_ff @(negedge sclk or negedge hrst_n) begin
    if (!hrst_n) begin
      sreq1_reg <= 1'b0;
      sreq2_reg <= 1'b0;
    end else begin
      sreq1_reg <= req_reg;
      sreq2_reg <= sreq1_reg;
    end
  end

  assign s_pend = (sreq2_reg != sack_reg);

  always_ff @(negedge sclk or negedge srst_n) begin
    if (!srst_n) begin
      scnt_reg <= 5'h00;
    end else if (fs_act) begin
      scnt_reg <= 5'h01;
    end else if (s_last) begin
      scnt_reg <= 5'h00;
    end else begin
      scnt_reg <= 5'(scnt_reg + 1'b1);
    end
  end

  always_ff @(negedge sclk or negedge hrst_n) begin
    if (!hrst_n) begin
      srx_reg <= '0;
      shold_reg <= '0;
      stg_reg <= 1'b0;
      sack_reg <= 1'b0;
    end else begin
      srx_reg <= s_word;
      if (s_last) begin
        shold_reg <= s_word;
        stg_reg <= ~stg_reg;
        if (s_pend) begin
          sack_reg <= ~sack_reg;
        end
      end
    end
  end

  always_ff @(posedge sclk or negedge srst_n) begin
    if (!srst_n) begin
      ocnt_reg <= 5'h00;
    end else begin
      ocnt_reg <= scnt_reg;
    end
  end

  assign oidx = 4'(msb - ocnt_reg[3:0]);

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign shift_clock_o = act_reg ^ cfg_i.ckp;
  assign shift_clock_oe_o = m_run & ~cfg_i.dis_sck;
  // stage is loaded before the frame; the request sync lags the first edges
  assign serial_data_out_o = cfg_i.master ? mtx_reg[msb]
                                          : stage_reg[oidx];
  assign serial_data_out_oe_o = ~cfg_i.dis_sdo &
                                (m_run | (s_run & srst_n));
  assign slave_select_n_oe_o = m_run & cfg_i.frame_en;
  assign slave_select_n_o = ((st_reg == SPP_SHIFT) & (hcnt_reg < 6'h02))
                            ~^ cfg_i.frame_pol;
endmodule : spp_top

/* File: verif/spp_top_asserts.sv */
// Purpose: concurrent checks on the serial port top ports
// Assumes: configuration only changes while module_enable is low
// Notes:   bound to every spp_top instance

// ------------------------------------------------------------------
// checker
// ------------------------------------------------------------------
module spp_top_asserts
  import spp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // configuration and status
  input wire spp_cfg_s cfg_i,
  input wire logic ovf_clr_i,
  input wire spp_stat_s stat_o,
  // data buffer
  input wire logic buf_wr_i,
  input wire logic buf_wr_ready_o,
  input wire logic buf_rd_i,
  input wire logic buf_rvalid_o,
  input wire logic [WORD_W-1:0] buf_rdata_o,
  // pin enables
  input wire logic shift_clock_oe_o,
  input wire logic serial_data_out_oe_o,
  input wire logic slave_select_n_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  en_off_a: assert property (!cfg_i.en && !$past(cfg_i.en) |->
    !shift_clock_oe_o && !serial_data_out_oe_o) else $error("pins driven while disabled");
  fifo_full_a: assert property (cfg_i.en && cfg_i.fifo_en && stat_o.tx_cnt == LVL_ENH
    |-> !buf_wr_ready_o && stat_o.tx_full) else $error("fifo takes a ninth word");
  tx_flag_a: assert property (cfg_i.en && !cfg_i.fifo_en && buf_wr_i && buf_wr_ready_o
    |=> stat_o.tx_full) else $error("transmit full not set on write");
  rx_clear_a: assert property (cfg_i.en && !cfg_i.fifo_en && buf_rd_i && buf_rvalid_o
    |=> !stat_o.rx_full) else $error("receive full not cleared on read");
  ovf_hold_a: assert property (stat_o.rx_ovf && !ovf_clr_i && cfg_i.en
    |=> stat_o.rx_ovf) else $error("overflow flag lost");
  ovf_cause_a: assert property ($rose(stat_o.rx_ovf) |-> $past(stat_o.rx_full))
    else $error("overflow without full receive side");
  slave_clk_a: assert property (!cfg_i.master |-> !shift_clock_oe_o)
    else $error("slave drives shift clock");
  byte_high_a: assert property (buf_rvalid_o && !cfg_i.word_width_select
    |-> buf_rdata_o[15:8] == 8'h00) else $error("byte read has upper bits");
  sdo_off_a: assert property (cfg_i.dis_sdo |-> !serial_data_out_oe_o)
    else $error("data out driven while unused");
  sync_off_a: assert property (!(cfg_i.master && cfg_i.frame_en) |-> !slave_select_n_oe_o)
    else $error("select driven outside framed master");
endmodule : spp_top_asserts

bind spp_top spp_top_asserts chk_u (
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .cfg_i(cfg_i),
  .ovf_clr_i(ovf_clr_i),
  .stat_o(stat_o),
  .buf_wr_i(buf_wr_i),
  .buf_wr_ready_o(buf_wr_ready_o),
  .buf_rd_i(buf_rd_i),
  .buf_rvalid_o(buf_rvalid_o),
  .buf_rdata_o(buf_rdata_o),
  .shift_clock_oe_o(shift_clock_oe_o),
  .serial_data_out_oe_o(serial_data_out_oe_o),
  .slave_select_n_oe_o(slave_select_n_oe_o)
);

/* File: verif/spp_remote.sv */
// Purpose: remote shift register on the far side of the link
// Assumes: clock idles low, samples on the edge that cke selects
// Notes:   echoes each word one frame later

// ------------------------------------------------------------------
// remote
// ------------------------------------------------------------------
module spp_remote
  import spp_pkg::*;
(
  // link pins
  input wire logic sck_i,
  input wire logic sdo_i,
  output logic sdi_o,
  // width and edge
  input wire logic word_width_select_i,
  input wire logic cke_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WORD_W-1:0] sr_reg = 16'h0000;

  initial sdi_o = 1'h0;
  // sample on leading edge when cke set, else trailing; present on the other
  always @(sck_i) begin
    if (sck_i == cke_i) begin
      sr_reg <= {sr_reg[WORD_W-2:0], sdo_i};
    end else begin
      sdi_o <= word_width_select_i ? sr_reg[MSB_WORD] : sr_reg[MSB_BYTE];
    end
  end
endmodule : spp_remote

/* File: verif/spp_top_bench.sv */
// Purpose: self-checking bench for the serial peripheral port
// Assumes: remote sees the shift clock idling low, remote echoes words
// Notes:   master, fifo overflow and slave link runs

module spp_top_bench
  import spp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  spp_cfg_s cfg = '0;
  logic [7:0] div = 8'h03;
  logic ovf_clr = 1'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [WORD_W-1:0] wdata = 16'h0000;
  logic lk_sck = 1'h0;
  logic lk_sdi = 1'h0;
  logic lk_ss_n = 1'h1;
  logic seen = 1'h0;
  spp_stat_s stat;
  logic wr_rdy, rvalid, sck_o, sck_oe, sdo_o, sdo_oe, ss_n_o, ss_n_oe, rm_sdi;
  logic [WORD_W-1:0] rdata, w, pw, r, g;
  logic [WORD_W-1:0] q[$];
  logic [31:0] seed = 32'hA65F;
  logic [4:0] tbl [5] = '{5'h00, 5'h10, 5'h18, 5'h04, 5'h17};
  int failures = 0;
  int checks = 0;
  int n;
  wire logic sck_w = sck_oe ? sck_o : lk_sck;
  wire logic sdo_w = sdo_oe ? sdo_o : 1'h1;

  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (ss_n_oe === 1'h1 && ss_n_o === cfg.frame_pol) seen <= 1'h1;
  end

  spp_top dut_u (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .cfg_i(cfg),
    .clk_div_i(div),
    .ovf_clr_i(ovf_clr),
    .stat_o(stat),
    .buf_wr_i(wr),
    .buf_wdata_i(wdata),
    .buf_wr_ready_o(wr_rdy),
    .buf_rd_i(rd),
    .buf_rvalid_o(rvalid),
    .buf_rdata_o(rdata),
    .shift_clock_i(sck_w),
    .shift_clock_o(sck_o),
    .shift_clock_oe_o(sck_oe),
    .serial_data_in_i(cfg.master ? rm_sdi : lk_sdi),
    .serial_data_out_o(sdo_o),
    .serial_data_out_oe_o(sdo_oe),
    .slave_select_n_i(lk_ss_n),
    .slave_select_n_o(ss_n_o),
    .slave_select_n_oe_o(ss_n_oe)
  );
  spp_remote rm_u (
    .sck_i(sck_w ^ cfg.ckp),
    .sdo_i(sdo_w),
    .sdi_o(rm_sdi),
    .word_width_select_i(cfg.word_width_select),
    .cke_i(cfg.cke)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [WORD_W-1:0] fit(input logic [WORD_W-1:0] v, input logic m16);
    return m16 ? v : (v & MASK_BYTE);
  endfunction : fit
  function automatic spp_cfg_s mk(input logic [4:0] t, input logic mst);
    spp_cfg_s c;
    c = '0;
    c.master = mst;
    c.word_width_select = t[4];
    c.fifo_en = t[3];
    c.frame_en = t[2];
    c.frame_pol = t[1];
    c.dis_sdo = t[0];
    c.cke = !t[2];
    c.ckp = t[1];
    c.slave_select_enable = !mst;
    return c;
  endfunction : mk
  task automatic chk(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] o);
    checks++;
    if (o !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, o);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic setup(input spp_cfg_s c);
    cfg.en <= 1'h0;
    seen <= 1'h0;
    @(posedge clk_i);
    cfg <= c;
    ovf_clr <= 1'h1;
    div <= {6'h00, seed[1:0]} + 8'h03;
    @(posedge clk_i);
    chk("ready while off", 16'h0000, {15'h0000, wr_rdy});
    ovf_clr <= 1'h0;
    cfg.en <= 1'h1;
    @(posedge clk_i);
  endtask : setup
  task automatic put(input logic [WORD_W-1:0] v);
    wr <= 1'h1;
    wdata <= v;
    @(posedge clk_i);
    for (int i = 0; i < 4000 && wr_rdy !== 1'h1; i++) @(posedge clk_i);
    wr <= 1'h0;
  endtask : put
  task automatic get(output logic [WORD_W-1:0] v);
    for (int i = 0; i < 4000 && rvalid !== 1'h1; i++) @(posedge clk_i);
    rd <= 1'h1;
    @(posedge clk_i);
    v = rdata;
    rd <= 1'h0;
    @(posedge clk_i);
  endtask : get
  task automatic frame(input logic [WORD_W-1:0] v, output logic [WORD_W-1:0] o);
    #7 lk_ss_n = 1'h0;
    #9;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      lk_sdi = v[i];
      #3 o[i] = sdo_w;
      lk_sck = 1'h1;
      #3 lk_sck = 1'h0;
    end
    #9 lk_ss_n = 1'h1;
    lk_sdi = ~lk_sdi;
  endtask : frame

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'h1;
    @(posedge clk_i);
    foreach (tbl[i]) begin
      setup(mk(tbl[i], 1'h1));
      for (int k = 0; k < 4; k++) begin
        seed = xs(seed);
        w = seed[15:0];
        put(w);
        @(negedge clk_i);
        if (!tbl[i][3]) chk("tx full", 16'h0001, {15'h0000, stat.tx_full});
        @(posedge clk_i);
        get(r);
        if (k > 0) chk("master rx", fit(tbl[i][0] ? 16'hFFFF : pw, tbl[i][4]), r);
        pw = w;
      end
      if (tbl[i][2]) chk("frame sync", 16'h0001, {15'h0000, seen});
      if (tbl[i][2]) chk("sync idle", {15'h0000, ~tbl[i][1]}, {15'h0000, ss_n_o});
    end
    setup(mk(5'h08, 1'h1));
    wr <= 1'h1;
    n = 0;
    do begin
      seed = xs(seed);
      wdata <= seed[15:0];
      @(posedge clk_i);
      if (wr_rdy === 1'h1) q.push_back(wdata);
      n++;
    end while (wr_rdy === 1'h1 && n < 40);
    wr <= 1'h0;
    @(negedge clk_i);
    chk("tx level", {10'h000, LVL_ENH}, {10'h000, stat.tx_cnt});
    for (int i = 0; i < 9000 && stat.rx_ovf !== 1'h1; i++) @(posedge clk_i);
    @(negedge clk_i);
    chk("overflow", 16'h0001, {15'h0000, stat.rx_ovf});
    chk("rx level", {10'h000, LVL_ENH}, {10'h000, stat.rx_cnt});
    @(posedge clk_i);
    for (int k = 0; k < 8; k++) begin
      get(r);
      if (k > 0) chk("fifo rx", fit(q[k-1], 1'h0), r);
    end
    ovf_clr <= 1'h1;
    @(posedge clk_i);
    ovf_clr <= 1'h0;
    @(negedge clk_i);
    chk("ovf and empty", 16'h0001, {14'h0000, stat.rx_ovf, stat.rx_empty});
    @(posedge clk_i);
    setup(mk(5'h10, 1'h0));
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      w = seed[15:0];
      put(w);
      repeat (8) @(posedge clk_i);
      frame(seed[31:16], g);
      chk("slave tx", w, g);
      @(posedge clk_i);
      get(r);
      chk("slave rx", seed[31:16], r);
    end
    end_sim();
  end

  initial begin
    #3ms;
    failures++;
    end_sim();
  end
endmodule : spp_top_bench
